// >>> common/hws_regs.svh
// Register offsets, field positions, reset values and timing for the waveform sequencer
`ifndef HWS_REGS_SVH
`define HWS_REGS_SVH
`define HWS_ADDR_SLOT1 8'h04
`define HWS_ADDR_SLOT8 8'h0B
`define HWS_ADDR_GO 8'h0C
`define HWS_ADDR_ODT 8'h0D
`define HWS_SLOT_RST 8'h00
`define HWS_GO_RST 1'h0
`define HWS_ODT_RST 8'h00
`define HWS_WAIT_BIT 7
`define HWS_ID_MSB 6
`define HWS_GO_BIT 0
`define HWS_NUM_SLOTS 8
`define HWS_IDX_END 4'h8
`define HWS_MODE_INT 3'h0
`define HWS_MODE_EDGE 3'h1
`define HWS_MODE_LEVEL 3'h2
`define HWS_MODE_DIAG 3'h6
`define HWS_MODE_CAL 3'h7
`define HWS_WAIT_UNIT_MS 10
`define HWS_CLK_PERIOD_NS 5
`define HWS_WAIT_CYCLES (`HWS_WAIT_UNIT_MS * 1000000 / `HWS_CLK_PERIOD_NS)
`define HWS_IVL_SLOW_MS 11'h005
`define HWS_IVL_FAST_MS 11'h001
`endif

// >>> common/hws_pkg.sv
// Types shared by the waveform sequencer modules
package hws_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_PLAY = 5'h04,
    ST_WAIT = 5'h08,
    ST_PROC = 5'h10
  } hws_state_t;
  typedef logic [6:0] hws_id_t;
  typedef logic [3:0] hws_idx_t;
endpackage

// >>> verilog/hws_wait_timer.sv
// Wait slot timer: 10 ms prescaler and a down-counter of units
`timescale 1ns/1ps
`include "hws_regs.svh"
module hws_wait_timer #(
  parameter int unsigned WAIT_CYCLES = `HWS_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic clear,
  input wire hws_pkg::hws_id_t count,
  // Status
  output logic done
);
  localparam int PW = $clog2(WAIT_CYCLES + 1);
  logic [PW-1:0] pre_ff;
  hws_pkg::hws_id_t unit_ff;
  logic run_ff;
  logic done_ff;
  wire unit_end = (pre_ff == PW'(WAIT_CYCLES - 1));
  wire zero_left = (unit_ff == 7'h00);
  assign done = done_ff;
  // Counts whole units from the load; a count of zero ends at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff <= '0;
      unit_ff <= 7'h00;
      run_ff <= 1'h0;
      done_ff <= 1'h0;
    end else begin
      done_ff <= run_ff & zero_left & ~clear & ~load;
      if (clear) begin
        run_ff <= 1'h0;
      end else if (load) begin
        unit_ff <= count;
        pre_ff <= '0;
        run_ff <= 1'h1;
      end else if (run_ff & zero_left) begin
        run_ff <= 1'h0;
      end else if (run_ff) begin
        pre_ff <= unit_end ? '0 : pre_ff + PW'(1);
        if (unit_end) begin
          unit_ff <= unit_ff - 7'h01;
        end
      end
    end
  end
endmodule

// >>> verilog/hws_sequencer.sv
// Waveform sequencer: slot registers, launch control, playback walk and overdrive offset
`timescale 1ns/1ps
`include "hws_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Wait slot idles seven-bit count times 10 ms with drive off.
// - Non-wait slot low seven bits are a waveform identifier to play.
// - Identifier indexes a waveform within the selected library.
// - Start in sequence mode begins at the first slot.
// - After a waveform, advance and play next slot only if non-zero.
// - Stop at first zero identifier or after eight slots.
// - Start launches the process chosen by the mode field.
// - Start bit reads one until the sequence ends, then self-clears.
// - Host writing zero to start aborts the remaining sequence.
// - External trigger modes set or clear start from the trigger pin.
// - Start also launches calibration or diagnostics per mode.
// - Overdrive portion is the samples at the waveform's maximum value.
// - Overdrive offset applies in open loop only; ignored when closed.
// - Overdrive offset is an eight-bit two's complement value.
// - Overdrive change in ms is offset times sample period setting.
// - Library field picks the library used when start is set.
// - Calibration starts on start bit; completion clears start.
module hws_sequencer #(
  parameter int unsigned WAIT_CYCLES = `HWS_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Configuration from neighbouring registers
  input wire logic [2:0] mode_sel,
  input wire logic [2:0] lib_sel,
  input wire logic loop_closed,
  input wire logic sample_period_setting,
  // Trigger pin
  input wire logic ext_trig,
  // Playback engine
  output logic play_req,
  output logic [2:0] play_lib,
  output logic [6:0] play_id,
  output logic drive_en,
  input wire logic play_done,
  input wire logic wave_smp_vld,
  input wire logic [7:0] wave_smp,
  input wire logic [7:0] wave_peak,
  output logic od_portion,
  output logic [10:0] od_adjust_ms,
  // Calibration and diagnostic engines
  output logic cal_run,
  output logic diag_run,
  input wire logic proc_done,
  // Status
  output logic seq_busy
);
  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic slot_hit(input logic [7:0] a);
    slot_hit = (a >= `HWS_ADDR_SLOT1) && (a <= `HWS_ADDR_SLOT8);
  endfunction

  function automatic logic [2:0] slot_num(input logic [7:0] a);
    logic [7:0] d;
    d = a - `HWS_ADDR_SLOT1;
    slot_num = d[2:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] slot_ff [`HWS_NUM_SLOTS];
  logic go_ff;
  logic [7:0] odt_ff;
  hws_pkg::hws_state_t st_ff;
  hws_pkg::hws_state_t nxt_st;
  hws_pkg::hws_idx_t idx_ff;
  hws_pkg::hws_idx_t nxt_idx;
  logic trig_s1_ff;
  logic trig_s2_ff;
  logic trig_d_ff;
  logic [7:0] rdata_ff;
  logic play_req_ff;
  logic [2:0] play_lib_ff;
  hws_pkg::hws_id_t play_id_ff;
  logic drive_en_ff;
  logic cal_run_ff;
  logic diag_run_ff;
  logic od_portion_ff;
  logic [10:0] od_adj_ff;
  logic seq_busy_ff;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_slot = reg_wr_en & slot_hit(reg_addr);
  wire wr_go = reg_wr_en & (reg_addr == `HWS_ADDR_GO);
  wire wr_odt = reg_wr_en & (reg_addr == `HWS_ADDR_ODT);
  wire [2:0] wr_num = slot_num(reg_addr);
  wire [7:0] rd_mux = slot_hit(reg_addr) ? slot_ff[slot_num(reg_addr)] :
                      (reg_addr == `HWS_ADDR_GO) ? {7'h00, go_ff} :
                      (reg_addr == `HWS_ADDR_ODT) ? odt_ff : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Current slot and mode decode
  wire at_end = idx_ff[3];
  wire [7:0] cur_slot = slot_ff[idx_ff[2:0]];
  wire cur_wait = cur_slot[`HWS_WAIT_BIT];
  wire [6:0] cur_id = cur_slot[`HWS_ID_MSB:0];
  wire seq_end = at_end | (~cur_wait & (cur_id == 7'h00));
  wire is_idle = (st_ff == hws_pkg::ST_IDLE);
  wire is_fetch = (st_ff == hws_pkg::ST_FETCH);
  wire is_play = (st_ff == hws_pkg::ST_PLAY);
  wire is_wait = (st_ff == hws_pkg::ST_WAIT);
  wire is_proc = (st_ff == hws_pkg::ST_PROC);
  wire mode_edge = (mode_sel == `HWS_MODE_EDGE);
  wire mode_level = (mode_sel == `HWS_MODE_LEVEL);
  wire mode_seq = (mode_sel == `HWS_MODE_INT) | mode_edge | mode_level;
  wire mode_cal = (mode_sel == `HWS_MODE_CAL);
  wire mode_diag = (mode_sel == `HWS_MODE_DIAG);
  wire launch = is_idle & go_ff;
  // Modes with no process behind the start bit just drop it again
  wire launch_none = launch & ~mode_seq & ~mode_cal & ~mode_diag;
  wire abort = ~is_idle & ~go_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger pin and start bit
  wire trig_rise = trig_s2_ff & ~trig_d_ff;
  wire trig_fall = ~trig_s2_ff & trig_d_ff;
  wire hw_set = trig_rise & (mode_edge | mode_level);
  wire fin = (is_fetch & seq_end) | (is_proc & proc_done) | launch_none;
  wire hw_clr = fin | (trig_fall & mode_level);
  // A hardware set outranks a host clear in the same cycle
  wire nxt_go = hw_set | (wr_go ? reg_wdata[`HWS_GO_BIT] : (go_ff & ~hw_clr));

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    case (st_ff)
      hws_pkg::ST_IDLE: begin
        if (launch & mode_seq) begin
          nxt_st = hws_pkg::ST_FETCH;
          nxt_idx = 4'h0;
        end else if (launch & (mode_cal | mode_diag)) begin
          nxt_st = hws_pkg::ST_PROC;
        end
      end
      hws_pkg::ST_FETCH: begin
        if (seq_end) begin
          nxt_st = hws_pkg::ST_IDLE;
        end else if (cur_wait) begin
          nxt_st = hws_pkg::ST_WAIT;
        end else begin
          nxt_st = hws_pkg::ST_PLAY;
        end
      end
      hws_pkg::ST_PLAY: begin
        if (play_done) begin
          nxt_st = hws_pkg::ST_FETCH;
          nxt_idx = idx_ff + 4'h1;
        end
      end
      hws_pkg::ST_WAIT: begin
        if (tmr_done) begin
          nxt_st = hws_pkg::ST_FETCH;
          nxt_idx = idx_ff + 4'h1;
        end
      end
      hws_pkg::ST_PROC: begin
        if (proc_done) begin
          nxt_st = hws_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st = hws_pkg::ST_IDLE;
      end
    endcase
    if (abort) begin
      nxt_st = hws_pkg::ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output next values
  wire load_wait = is_fetch & ~seq_end & cur_wait & go_ff;
  wire nxt_play = (nxt_st == hws_pkg::ST_PLAY);
  wire nxt_proc = (nxt_st == hws_pkg::ST_PROC);
  wire [10:0] ivl_ms = sample_period_setting ? `HWS_IVL_FAST_MS : `HWS_IVL_SLOW_MS;
  wire [10:0] od_mult = 11'(signed'(odt_ff)) * ivl_ms;
  wire [10:0] nxt_od_adj = loop_closed ? 11'h000 : od_mult;
  wire nxt_od_portion = nxt_play & wave_smp_vld & (wave_smp == wave_peak);

  ////////////////////////////////////////////////////////////////////////////////
  // Wait timer
  hws_wait_timer #(
    .WAIT_CYCLES(WAIT_CYCLES)
  ) u_wait (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(load_wait),
    .clear(abort),
    .count(cur_id),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Slot registers
  genvar gi;
  generate
    for (gi = 0; gi < `HWS_NUM_SLOTS; gi++) begin : g_slot
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          slot_ff[gi] <= `HWS_SLOT_RST;
        end else if (wr_slot && (wr_num == 3'(gi))) begin
          slot_ff[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers and pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      go_ff <= `HWS_GO_RST;
      odt_ff <= `HWS_ODT_RST;
      trig_s1_ff <= 1'h0;
      trig_s2_ff <= 1'h0;
      trig_d_ff <= 1'h0;
      rdata_ff <= 8'h00;
    end else begin
      go_ff <= nxt_go;
      if (wr_odt) begin
        odt_ff <= reg_wdata;
      end
      trig_s1_ff <= ext_trig;
      trig_s2_ff <= trig_s1_ff;
      trig_d_ff <= trig_s2_ff;
      if (reg_rd_en) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= hws_pkg::ST_IDLE;
      idx_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Engine-facing outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      play_req_ff <= 1'h0;
      play_lib_ff <= 3'h0;
      play_id_ff <= 7'h00;
      drive_en_ff <= 1'h0;
      cal_run_ff <= 1'h0;
      diag_run_ff <= 1'h0;
      od_portion_ff <= 1'h0;
      od_adj_ff <= 11'h000;
      seq_busy_ff <= 1'h0;
    end else begin
      play_req_ff <= nxt_play & ~is_play;
      drive_en_ff <= nxt_play;
      if (launch) begin
        play_lib_ff <= lib_sel;
      end
      if (is_fetch & ~seq_end) begin
        play_id_ff <= cur_id;
      end
      cal_run_ff <= nxt_proc & (is_proc ? cal_run_ff : mode_cal);
      diag_run_ff <= nxt_proc & (is_proc ? diag_run_ff : mode_diag);
      od_portion_ff <= nxt_od_portion;
      od_adj_ff <= nxt_od_adj;
      seq_busy_ff <= (nxt_st != hws_pkg::ST_IDLE);
    end
  end

  assign reg_rdata = rdata_ff;
  assign play_req = play_req_ff;
  assign play_lib = play_lib_ff;
  assign play_id = play_id_ff;
  assign drive_en = drive_en_ff;
  assign cal_run = cal_run_ff;
  assign diag_run = diag_run_ff;
  assign od_portion = od_portion_ff;
  assign od_adjust_ms = od_adj_ff;
  assign seq_busy = seq_busy_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_seq_launch;
    is_idle && go_ff && mode_seq && !wr_go && !hw_clr;
  endsequence

  sequence s_wait_fetch;
    is_fetch && !seq_end && cur_wait && go_ff && !wr_go;
  endsequence

  first_slot_a: assert property (s_seq_launch |=> is_fetch && idx_ff == 4'h0)
    else $error("launch did not start at first slot");

  wait_enter_a: assert property (s_wait_fetch |=> is_wait)
    else $error("wait slot did not enter wait");

  play_id_a: assert property (is_fetch && !seq_end && !cur_wait && go_ff && !wr_go
    |=> is_play && play_req && drive_en && play_id == $past(cur_id))
    else $error("wrong identifier or no request");

  zero_stop_a: assert property (is_fetch && seq_end |=> is_idle && !drive_en)
    else $error("sequence did not stop at end");

  idx_bound_a: assert property (idx_ff <= `HWS_IDX_END)
    else $error("slot index past eight");

  abort_go_a: assert property (!is_idle && !go_ff |=> is_idle ##1 !drive_en && !play_req)
    else $error("cleared start did not abort");

  go_hold_a: assert property (go_ff && !is_idle && !fin && !wr_go && !(trig_fall && mode_level)
    |=> go_ff)
    else $error("start bit dropped early");

  go_done_a: assert property (is_proc && proc_done && !wr_go && !hw_set |=> !go_ff && is_idle)
    else $error("process end did not clear start");

  proc_run_a: assert property (is_idle && go_ff && mode_cal && !wr_go && !hw_clr
    |=> ##1 cal_run && !diag_run)
    else $error("calibration not launched");

  odt_closed_a: assert property (loop_closed |=> od_adjust_ms == 11'h000)
    else $error("offset used in closed loop");

  odt_value_a: assert property (!loop_closed && $stable(odt_ff) && $stable(sample_period_setting)
    |=> $signed(od_adjust_ms) == $signed($past(odt_ff)) * ($past(sample_period_setting) ? 1 : 5))
    else $error("overdrive change wrong");

  trig_edge_a: assert property (mode_edge && trig_rise |=> go_ff)
    else $error("trigger edge did not set start");
endmodule

// >>> verification/hws_engine_model.sv
// Playback, calibration and diagnostic engine model for the waveform sequencer
`timescale 1ns/1ps
module hws_engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // From sequencer; done_delay from the testbench
  input wire logic play_req,
  input wire logic drive_en,
  input wire logic cal_run,
  input wire logic diag_run,
  input wire logic [7:0] done_delay,
  // To sequencer
  output logic play_done,
  output logic proc_done,
  output logic wave_smp_vld,
  output logic [7:0] wave_smp,
  output logic [7:0] wave_peak
);
  logic [7:0] cnt_ff;
  logic [7:0] pc_ff;
  logic busy_ff;
  logic proc_ff;
  assign wave_peak = 8'h04;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_ff, pc_ff, busy_ff, proc_ff, play_done, proc_done, wave_smp_vld} <= '0;
      wave_smp <= 8'h00;
    end else begin
      play_done <= 1'b0;
      proc_done <= 1'b0;
      if (play_req) begin
        busy_ff <= 1'b1;
        cnt_ff <= done_delay;
      end else if (busy_ff && !drive_en) begin
        busy_ff <= 1'b0;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        play_done <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
      if (!cal_run && !diag_run) begin
        pc_ff <= 8'h00;
        proc_ff <= 1'b0;
      end else if (!proc_ff) begin
        pc_ff <= pc_ff + 8'h01;
        if (pc_ff == done_delay) begin
          proc_done <= 1'b1;
          proc_ff <= 1'b1;
        end
      end
      wave_smp_vld <= drive_en;
      // Released sample lines flip so a stale value never looks like a sample
      wave_smp <= drive_en ? cnt_ff : ~wave_smp;
    end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking testbench for the waveform sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned WC = 20;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, done_delay = 8'h06, rd;
  logic [2:0] mode_sel = 3'h0, lib_sel = 3'h3, play_lib;
  logic loop_closed = 1'b0, sample_period_setting = 1'b0, ext_trig = 1'b0;
  logic play_req, drive_en, play_done, wave_smp_vld, od_portion, cal_run, diag_run, proc_done, seq_busy;
  logic [6:0] play_id;
  logic [7:0] wave_smp, wave_peak;
  logic [10:0] od_adjust_ms;
  int miscompares = 0, n_checks = 0, cyc = 0, od_seen = 0;
  logic [6:0] ids[$];
  logic [2:0] libs[$];
  int tms[$];
  always #2.5 sys_clk = ~sys_clk;
  hws_sequencer #(.WAIT_CYCLES(WC)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mode_sel(mode_sel), .lib_sel(lib_sel), .loop_closed(loop_closed),
    .sample_period_setting(sample_period_setting), .ext_trig(ext_trig), .play_req(play_req),
    .play_lib(play_lib), .play_id(play_id), .drive_en(drive_en), .play_done(play_done),
    .wave_smp_vld(wave_smp_vld), .wave_smp(wave_smp), .wave_peak(wave_peak), .od_portion(od_portion),
    .od_adjust_ms(od_adjust_ms), .cal_run(cal_run), .diag_run(diag_run), .proc_done(proc_done),
    .seq_busy(seq_busy));
  hws_engine_model engine (.sys_clk(sys_clk), .rst_b(rst_b), .play_req(play_req), .drive_en(drive_en),
    .cal_run(cal_run), .diag_run(diag_run), .done_delay(done_delay), .play_done(play_done),
    .proc_done(proc_done), .wave_smp_vld(wave_smp_vld), .wave_smp(wave_smp), .wave_peak(wave_peak));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (play_req === 1'b1) begin
      ids.push_back(play_id);
      libs.push_back(play_lib);
      tms.push_back(cyc);
    end
    if (od_portion === 1'b1) od_seen <= od_seen + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1 reg_wr_en = 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge sys_clk);
    #1 reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1 reg_rd_en = 1'b0;
    rd = reg_rdata;
  endtask
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && seq_busy !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  // Load slots from a table and launch in internal mode; start must read zero afterwards
  task automatic run_seq(input logic [7:0] s[8]);
    for (int i = 0; i < 8; i++) wr(8'h04 + i[7:0], s[i]);
    ids.delete();
    tms.delete();
    libs.delete();
    wr(8'h0C, 8'h01);
    // Change the library only once launch has latched it
    repeat (3) @(posedge sys_clk);
    #1 lib_sel = 3'h5;
    wait_idle(3000);
    rdt(8'h0C);
    chk(rd, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int a = 4; a <= 8'h0E; a++) begin
      rdt(a[7:0]);
      chk(rd, 8'h00);
    end
    rdt(8'h20);
    chk(rd, 8'h00);
    wr(8'h0B, 8'hA5);
    rdt(8'h0B);
    chk(rd, 8'hA5);
    wr(8'h0D, 8'hFE);
    rdt(8'h0D);
    chk(rd, 8'hFE);
    // Overdrive change: -2 times 5 ms, then 1 ms, then none in closed loop
    chk(od_adjust_ms, 11'h7F6);
    #5 sample_period_setting = 1'b1;
    #10 chk(od_adjust_ms, 11'h7FE);
    loop_closed = 1'b1;
    #10 chk(od_adjust_ms, 11'h000);
    loop_closed = 1'b0;
    run_seq('{8'h05, 8'h81, 8'h12, 8'h00, 8'h33, 8'h00, 8'h00, 8'h00});
    chk(ids.size(), 2);
    chk(ids[0], 7'h05);
    chk(ids[1], 7'h12);
    chk(libs[1], 3'h3);
    chk((tms[1] - tms[0]) >= (6 + WC), 1'b1);
    chk(drive_en, 1'b0);
    chk(od_seen > 0, 1'b1);
    lib_sel = 3'h3;
    run_seq('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    chk(ids.size(), 8);
    chk(ids[7], 7'h08);
    // Cancel in mid-waveform
    done_delay = 8'hC8;
    ids.delete();
    wr(8'h0C, 8'h01);
    for (int i = 0; i < 20 && drive_en !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    wr(8'h0C, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk(drive_en, 1'b0);
    chk(seq_busy, 1'b0);
    repeat (300) @(posedge sys_clk);
    chk(ids.size(), 1);
    done_delay = 8'h06;
    // Calibration, diagnostics, and a mode with no process
    for (int m = 0; m < 3; m++) begin
      mode_sel = (m == 0) ? 3'h7 : (m == 1) ? 3'h6 : 3'h3;
      wr(8'h0C, 8'h01);
      repeat (3) @(posedge sys_clk);
      #1 chk(cal_run, m == 0);
      chk(diag_run, m == 1);
      wait_idle(100);
      repeat (2) @(posedge sys_clk);
      rdt(8'h0C);
      chk(rd, 8'h00);
    end
    // Trigger pin: edge mode launches, level mode fall cancels
    wr(8'h04, 8'h07);
    wr(8'h05, 8'h00);
    mode_sel = 3'h1;
    ids.delete();
    ext_trig = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 ext_trig = 1'b0;
    repeat (5) @(posedge sys_clk);
    wait_idle(200);
    chk(ids.size(), 1);
    chk(ids[0], 7'h07);
    mode_sel = 3'h2;
    done_delay = 8'hC8;
    ext_trig = 1'b1;
    for (int i = 0; i < 20 && drive_en !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(drive_en, 1'b1);
    ext_trig = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk(drive_en, 1'b0);
    rdt(8'h0C);
    chk(rd, 8'h00);
    end_of_test();
  end
endmodule
